// ==== src/spp_pkg.sv ====
// package: constants and carrier types of the six-bit pin port
// Behaviour
// - port read returns pin levels, never latches
// - every reset makes all pins inputs
// - six pins; bits 7 and 6 read zero
// - pin three never drives, input only
// - alternate-function pins read as zero
// - shared pull-up and wake on pins 0,1,3
// - master clear: pull-up on, no wake
// - direction load copies working value to direction
// - direction 1 floats pin, 0 drives latch
// - option overrides pin two direction
// - timer pin source forces pin two input
// - direction write-only, all ones on reset
// - pins not latched; sampled at the read
// - output latches hold until port written
// - each other pin's direction set individually
// - bit set/clear rewrites all latches from pins
// - status bit 7 set only by wake reset
// - write lands cycle end, read samples start
package spp_pkg;

	// ****************************************
	// register map and reset values
	// ****************************************
	localparam int        PORT_W          = 6;
	localparam logic [4:0] ADDR_STATUS    = 5'h03;
	localparam logic [4:0] ADDR_DATA      = 5'h06;
	localparam logic [5:0] DIR_RESET      = 6'h3F;
	localparam logic [7:0] OPTION_RESET   = 8'hFF;
	localparam logic [5:0] LATCH_RESET    = 6'h00;

	// ****************************************
	// field positions
	// ****************************************
	localparam int OPT_WAKE_BIT    = 7;
	localparam int OPT_PULLUP_BIT  = 6;
	localparam int OPT_TMR_SRC_BIT = 5;
	localparam int STATUS_WAKE_BIT = 7;
	localparam int PIN_INPUT_ONLY  = 3;
	localparam int PIN_TIMER       = 2;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		WK_IDLE  = 2'b00,
		WK_ARMED = 2'b01,
		WK_FIRE  = 2'b10
	} spp_wake_t;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic       rmw;
		logic       rmw_set;
		logic [2:0] bit_sel;
		logic       dir_load;
		logic       option_load;
		logic [4:0] addr;
		logic [7:0] data;
	} spp_req_t;

	typedef struct packed {
		logic [5:0] alt_fn;
		logic       master_clear_input_en;
	} spp_cfg_t;

endpackage

// ==== src/spp_port.sv ====
// module: six-bit pin port with direction, option overrides and wake
`timescale 1ns/100ps
module spp_port
	import spp_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          arst_n,
	input  wire logic          core_reset,
	input  wire logic          sleep,
	input  wire spp_req_t      req,
	input  wire spp_cfg_t      cfg,
	input  wire logic [5:0]    pin_in,
	output logic      [7:0]    rdata,
	output logic      [5:0]    pin_out,
	output logic      [5:0]    pin_oe,
	output logic      [5:0]    pin_pullup,
	output logic               wake_reset
);

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [5:0] pin_meta;
	logic [5:0] pin_sync;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_meta <= 6'h00;
			pin_sync <= 6'h00;
		end else begin
			pin_meta <= pin_in;
			pin_sync <= pin_meta;
		end
	end

	// ****************************************
	// state
	// ****************************************
	logic [5:0] pin_direction_control;
	logic [7:0] timer_pullup_wake_option;
	logic [5:0] latch;
	logic       wake_reset_flag;
	spp_wake_t  wake_state;
	logic [5:0] wake_ref;
	logic       port_reset;
	logic [5:0] port_view;
	logic [7:0] rmw_value;
	logic [5:0] wake_mask;
	logic       wake_hit;

	// wake reset acts like a core reset on direction and option
	assign port_reset = core_reset | (wake_state == WK_FIRE);
	assign wake_reset = (wake_state == WK_FIRE);

	// no input latch: the view is the synchronised pins of this cycle
	assign port_view = pin_sync & ~cfg.alt_fn;

	// ****************************************
	// direction control
	// ****************************************
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_direction_control <= DIR_RESET;
		end else if (port_reset) begin
			pin_direction_control <= DIR_RESET;
		end else if (req.dir_load) begin
			pin_direction_control <= req.data[5:0];
		end
	end

	// ****************************************
	// option register
	// ****************************************
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timer_pullup_wake_option <= OPTION_RESET;
		end else if (port_reset) begin
			timer_pullup_wake_option <= OPTION_RESET;
		end else if (req.option_load) begin
			timer_pullup_wake_option <= req.data;
		end
	end

	// ****************************************
	// output latches
	// ****************************************
	always_comb begin
		rmw_value = {2'b00, port_view};
		rmw_value[req.bit_sel] = req.rmw_set;
	end

	// power-on clears the latches; core and wake resets leave them, only a port write changes them
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			latch <= LATCH_RESET;
		end else if (req.rmw && req.addr == ADDR_DATA) begin
			latch <= rmw_value[5:0];
		end else if (req.wr && req.addr == ADDR_DATA) begin
			latch <= req.data[5:0];
		end
	end

	assign pin_out = latch;

	// ****************************************
	// drivers and pull-ups
	// ****************************************
	always_comb begin
		pin_oe = ~pin_direction_control;
		pin_oe[PIN_INPUT_ONLY] = 1'b0;
		if (timer_pullup_wake_option[OPT_TMR_SRC_BIT]) begin
			pin_oe[PIN_TIMER] = 1'b0;
		end
	end

	always_comb begin
		pin_pullup = 6'h00;
		pin_pullup[0] = ~timer_pullup_wake_option[OPT_PULLUP_BIT];
		pin_pullup[1] = ~timer_pullup_wake_option[OPT_PULLUP_BIT];
		pin_pullup[PIN_INPUT_ONLY] = ~timer_pullup_wake_option[OPT_PULLUP_BIT]
			| cfg.master_clear_input_en;
	end

	// ****************************************
	// read data
	// ****************************************
	// sampled at the edge that takes the read, so a write in the same
	// cycle is not yet seen on the pins
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= 8'h00;
		end else if (req.rd) begin
			if (req.addr == ADDR_DATA) begin
				rdata <= {2'b00, port_view};
			end else if (req.addr == ADDR_STATUS) begin
				rdata <= {wake_reset_flag, 7'h00};
			end else begin
				rdata <= 8'h00;
			end
		end
	end

	// ****************************************
	// wake on change
	// ****************************************
	always_comb begin
		wake_mask = 6'h00;
		wake_mask[0] = 1'b1;
		wake_mask[1] = 1'b1;
		wake_mask[PIN_INPUT_ONLY] = ~cfg.master_clear_input_en;
	end

	assign wake_hit = |((pin_sync ^ wake_ref) & wake_mask);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wake_state <= WK_IDLE;
			wake_ref <= 6'h00;
		end else begin
			unique case (wake_state)
				WK_IDLE: begin
					wake_ref <= pin_sync;
					if (sleep && !timer_pullup_wake_option[OPT_WAKE_BIT]) begin
						wake_state <= WK_ARMED;
					end
				end
				WK_ARMED: begin
					if (!sleep || timer_pullup_wake_option[OPT_WAKE_BIT]) begin
						wake_state <= WK_IDLE;
					end else if (wake_hit) begin
						wake_state <= WK_FIRE;
					end
				end
				WK_FIRE: begin
					wake_state <= WK_IDLE;
				end
				default: begin
					wake_state <= WK_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// wake reset flag
	// ****************************************
	// power-on clears; a wake reset sets it even if a core reset coincides
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wake_reset_flag <= 1'b0;
		end else if (wake_state == WK_FIRE) begin
			wake_reset_flag <= 1'b1;
		end else if (core_reset) begin
			wake_reset_flag <= 1'b0;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_port_read;
		req.rd && req.addr == ADDR_DATA;
	endsequence

	sequence s_wake_fire;
		wake_state == WK_FIRE;
	endsequence

	sequence s_port_rmw;
		req.rmw && req.addr == ADDR_DATA;
	endsequence

	sequence s_armed_stay;
		wake_state == WK_ARMED && sleep && !timer_pullup_wake_option[OPT_WAKE_BIT];
	endsequence

	property p_read_pins;
		s_port_read |=> rdata == {2'b00, $past(pin_sync & ~cfg.alt_fn)};
	endproperty
	a_read_pins: assert property (p_read_pins) else $error("port read not pin levels");

	property p_reset_dir;
		core_reset |=> pin_direction_control == DIR_RESET && pin_oe == 6'h00;
	endproperty
	a_reset_dir: assert property (p_reset_dir) else $error("reset left a driver on");

	property p_input_only;
		!pin_oe[PIN_INPUT_ONLY];
	endproperty
	a_input_only: assert property (p_input_only) else $error("pin three driven");

	property p_pullup;
		pin_pullup[1] == !timer_pullup_wake_option[OPT_PULLUP_BIT]
			&& pin_pullup[0] == pin_pullup[1];
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-up not shared");

	property p_master_clear_input;
		cfg.master_clear_input_en |-> pin_pullup[PIN_INPUT_ONLY] && !wake_mask[PIN_INPUT_ONLY];
	endproperty
	a_master_clear_input: assert property (p_master_clear_input) else $error("master clear pin setup wrong");

	property p_dir_load;
		req.dir_load && !port_reset |=> pin_direction_control == $past(req.data[5:0]);
	endproperty
	a_dir_load: assert property (p_dir_load) else $error("direction load lost");

	property p_drive;
		!pin_direction_control[0] |-> pin_oe[0] && pin_out[0] == latch[0];
	endproperty
	a_drive: assert property (p_drive) else $error("cleared direction not driving");

	property p_timer_pin;
		timer_pullup_wake_option[OPT_TMR_SRC_BIT] |-> !pin_oe[PIN_TIMER];
	endproperty
	a_timer_pin: assert property (p_timer_pin) else $error("timer pin driven");

	property p_latch_hold;
		!((req.wr || req.rmw) && req.addr == ADDR_DATA) |=> $stable(latch);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch changed unwritten");

	property p_rmw;
		s_port_rmw |=> $past(req.bit_sel) > 3'h5
			|| (({2'b00, latch} >> $past(req.bit_sel)) & 8'h01) == {7'h00, $past(req.rmw_set)};
	endproperty
	a_rmw: assert property (p_rmw) else $error("bit operation wrong");

	property p_wake_flag;
		s_wake_fire |=> wake_reset_flag && pin_direction_control == DIR_RESET;
	endproperty
	a_wake_flag: assert property (p_wake_flag) else $error("wake reset flag not set");

	property p_read_top;
		s_port_read |=> rdata[7:6] == 2'b00;
	endproperty
	a_read_top: assert property (p_read_top) else $error("unused bits read set");

	property p_read_alt;
		s_port_read |=> (rdata[5:0] & $past(cfg.alt_fn)) == 6'h00;
	endproperty
	a_read_alt: assert property (p_read_alt) else $error("alternate pin read set");

	property p_read_status;
		req.rd && req.addr == ADDR_STATUS |=> rdata == {$past(wake_reset_flag), 7'h00};
	endproperty
	a_read_status: assert property (p_read_status) else $error("status read wrong");

	property p_dir_each;
		pin_oe[5:4] == ~pin_direction_control[5:4] && pin_oe[1:0] == ~pin_direction_control[1:0];
	endproperty
	a_dir_each: assert property (p_dir_each) else $error("pin direction not own");

	property p_pin2_dir;
		!timer_pullup_wake_option[OPT_TMR_SRC_BIT]
			|-> pin_oe[PIN_TIMER] == !pin_direction_control[PIN_TIMER];
	endproperty
	a_pin2_dir: assert property (p_pin2_dir) else $error("pin two direction lost");

	property p_option_reset;
		port_reset |=> timer_pullup_wake_option == OPTION_RESET;
	endproperty
	a_option_reset: assert property (p_option_reset) else $error("option not reset");

	property p_write;
		req.wr && !req.rmw && req.addr == ADDR_DATA |=> latch == $past(req.data[5:0]);
	endproperty
	a_write: assert property (p_write) else $error("port write lost");

	property p_rmw_rest;
		s_port_rmw |=> ({2'b00, latch ^ $past(port_view)}
			& ~(8'h01 << $past(req.bit_sel))) == 8'h00;
	endproperty
	a_rmw_rest: assert property (p_rmw_rest) else $error("bit operation lost pins");

	property p_wake_pulse;
		s_wake_fire |=> !wake_reset;
	endproperty
	a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");

	property p_wake_change;
		s_armed_stay ##0 (pin_sync[1:0] != wake_ref[1:0]) |=> s_wake_fire;
	endproperty
	a_wake_change: assert property (p_wake_change) else $error("pin change missed");

	property p_wake_pin3;
		s_armed_stay ##0 (!cfg.master_clear_input_en && pin_sync[PIN_INPUT_ONLY] != wake_ref[PIN_INPUT_ONLY])
			|=> s_wake_fire;
	endproperty
	a_wake_pin3: assert property (p_wake_pin3) else $error("pin three change missed");

	property p_master_clear_input_quiet;
		s_armed_stay ##0 (cfg.master_clear_input_en && pin_sync[1:0] == wake_ref[1:0]) |=> !wake_reset;
	endproperty
	a_master_clear_input_quiet: assert property (p_master_clear_input_quiet) else $error("master clear pin woke");

	property p_flag_clear;
		core_reset && wake_state != WK_FIRE |=> !wake_reset_flag;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("wake flag kept");

	property p_wake_off;
		wake_state == WK_IDLE && timer_pullup_wake_option[OPT_WAKE_BIT] |=> wake_state == WK_IDLE;
	endproperty
	a_wake_off: assert property (p_wake_off) else $error("wake armed while off");

	property p_pullup_only;
		pin_pullup[5:4] == 2'b00 && !pin_pullup[PIN_TIMER];
	endproperty
	a_pullup_only: assert property (p_pullup_only) else $error("pull-up on wrong pin");

endmodule

// ==== tb/six_bit_general_pin_port_tb.sv ====
// testbench: reads, writes, direction, option, bit ops and wake of the pin port
`timescale 1ns/100ps
module six_bit_general_pin_port_tb
	import spp_pkg::*;
;
	logic       clk, arst_n, core_reset, sleep, wake_reset;
	spp_req_t   req;
	spp_cfg_t   cfg;
	logic [5:0] pin_in, pin_out, pin_oe, pin_pullup, ext_val, ext_en;
	logic [7:0] rdata;
	int         err_total, samples_checked, cycles, wakes;

	spp_port dut (.clk(clk), .arst_n(arst_n), .core_reset(core_reset), .sleep(sleep),
		.req(req), .cfg(cfg), .pin_in(pin_in), .rdata(rdata), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_pullup(pin_pullup), .wake_reset(wake_reset));
	spp_board board (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup(pin_pullup), .ext_val(ext_val), .ext_en(ext_en), .pin_lvl(pin_in));

	// ****************************************
	// clock, watchdog, helpers
	// ****************************************
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (wake_reset === 1'b1) wakes++;
		// ceiling well above the hundred or so cycles the run needs
		if (cycles == 2000) begin
			err_total++;
			results();
		end
	end

	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// k: 0 read, 1 write, 2 direction load, 3 option load, 4 bit op (d[7] set, d[2:0] bit)
	task automatic cmd(input int k, input logic [4:0] a, input logic [7:0] d);
		spp_req_t r;
		r = '0;
		r.rd = (k == 0);
		r.wr = (k == 1);
		r.dir_load = (k == 2);
		r.option_load = (k == 3);
		r.rmw = (k == 4);
		r.rmw_set = d[7];
		r.bit_sel = d[2:0];
		r.addr = a;
		r.data = d;
		@(negedge clk);
		req = r;
		@(negedge clk);
		req = '0;
	endtask

	// pins pass two sync flops before a read can see them
	task automatic settle();
		repeat (4) @(negedge clk);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		clk = 1'b0;
		arst_n = 1'b0;
		core_reset = 1'b0;
		sleep = 1'b0;
		req = '0;
		cfg.alt_fn = 6'h20;
		cfg.master_clear_input_en = 1'b1;
		ext_val = 6'h00;
		ext_en = 6'h3F;
		err_total = 0;
		samples_checked = 0;
		cycles = 0;
		wakes = 0;
		repeat (20) @(negedge clk);
		check("oe_rst", {2'b00, pin_oe}, 8'h00);
		check("pu_rst", {2'b00, pin_pullup}, 8'h08);
		arst_n = 1'b1;
		ext_val = 6'h3A;
		settle();
		cmd(0, ADDR_DATA, 8'h00);
		check("rd_in", rdata, 8'h1A);
		cmd(1, ADDR_DATA, 8'hFF);
		check("latch", {2'b00, pin_out}, 8'h3F);
		check("oe_hold", {2'b00, pin_oe}, 8'h00);
		cmd(1, 5'h07, 8'h00);
		check("wr_other", {2'b00, pin_out}, 8'h3F);
		cmd(0, 5'h07, 8'h00);
		check("rd_other", rdata, 8'h00);
		cmd(2, 5'h00, 8'h00);
		check("oe_all", {2'b00, pin_oe}, 8'h33);
		ext_val = 6'h00;
		settle();
		cmd(0, ADDR_DATA, 8'h00);
		check("rd_pins", rdata, 8'h13);
		cmd(3, 5'h00, 8'h1F);
		check("oe_tmr", {2'b00, pin_oe}, 8'h37);
		check("pu_on", {2'b00, pin_pullup}, 8'h0B);
		cmd(2, 5'h00, 8'h3E);
		check("oe_one", {2'b00, pin_oe}, 8'h01);
		check("latch_dir", {2'b00, pin_out}, 8'h3F);
		// let pin one float so only its pull-up sets the level
		ext_en = 6'h3D;
		settle();
		cmd(0, ADDR_DATA, 8'h00);
		check("rd_pu", rdata, 8'h03);
		ext_en = 6'h3F;
		settle();
		cmd(4, ADDR_DATA, 8'h81);
		check("bit_set", {2'b00, pin_out}, 8'h03);
		cmd(0, ADDR_STATUS, 8'h00);
		check("stat0", rdata, 8'h00);
		// wake: pin three is master clear, so only pins zero and one may wake
		sleep = 1'b1;
		settle();
		ext_val = 6'h08;
		repeat (10) @(negedge clk);
		check("no_wake", wakes[7:0], 8'h00);
		ext_val = 6'h0A;
		repeat (10) @(negedge clk);
		check("wake", wakes[7:0], 8'h01);
		sleep = 1'b0;
		check("oe_wake", {2'b00, pin_oe}, 8'h00);
		check("pu_wake", {2'b00, pin_pullup}, 8'h08);
		cmd(0, ADDR_STATUS, 8'h00);
		check("stat_wk", rdata, 8'h80);
		core_reset = 1'b1;
		@(negedge clk);
		core_reset = 1'b0;
		cmd(0, ADDR_STATUS, 8'h00);
		check("stat_cr", rdata, 8'h00);
		check("latch_cr", {2'b00, pin_out}, 8'h03);
		// pin three as plain input: shared pull-up and wake apply to it
		cfg.master_clear_input_en = 1'b0;
		@(negedge clk);
		check("pu_off", {2'b00, pin_pullup}, 8'h00);
		cmd(3, 5'h00, 8'h1F);
		check("pu_p3", {2'b00, pin_pullup}, 8'h0B);
		sleep = 1'b1;
		settle();
		ext_val = 6'h02;
		repeat (10) @(negedge clk);
		check("wake_p3", wakes[7:0], 8'h02);
		sleep = 1'b0;
		results();
	end
endmodule

// ==== tb/spp_board.sv ====
// board model: resolves each pin from port driver, board driver and pull-up
`timescale 1ns/100ps
module spp_board
	import spp_pkg::*;
(
	input  wire logic       clk,
	input  wire logic [5:0] pin_out,
	input  wire logic [5:0] pin_oe,
	input  wire logic [5:0] pin_pullup,
	input  wire logic [5:0] ext_val,
	input  wire logic [5:0] ext_en,
	output logic      [5:0] pin_lvl
);
	logic [5:0] flt = 6'h15;
	// undriven pins wander each cycle so a stale read cannot pass
	always @(posedge clk) flt <= ~flt;
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			if (pin_oe[i]) pin_lvl[i] = pin_out[i];
			else if (ext_en[i]) pin_lvl[i] = ext_val[i];
			else if (pin_pullup[i]) pin_lvl[i] = 1'b1;
			else pin_lvl[i] = flt[i];
		end
	end
endmodule
